// File: logic/dma_slave_pkg.sv
package dma_slave_pkg;
    localparam logic [3:0] off_address = 4'h0;
    localparam logic [3:0] off_page = 4'h2;
    localparam logic [3:0] off_count = 4'h4;
    localparam logic [3:0] off_status = 4'h8;
    localparam logic [3:0] off_command = 4'h8;
    localparam int region_bytes = 16;
    localparam logic [15:0] address_reset = 16'h0000;
    localparam logic [7:0] page_reset = 8'h00;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam int disable_bit = 2;
    localparam logic [15:0] io_base_reset = 16'h0000;
    localparam logic [15:0] step_8bit = 16'h0001;
    localparam logic [15:0] step_16bit = 16'h0002;
    localparam logic [3:0] flags_set = 4'hf;
    localparam logic [3:0] flags_reset = 4'h0;
    localparam logic disable_reset = 1'b0;

    typedef struct packed {
        logic [15:0] base_addr;
        logic [15:0] cur_addr;
        logic [7:0] page;
        logic [15:0] base_count;
        logic [15:0] cur_count;
        logic [3:0] tc_flags;
        logic controller_disable;
        logic [31:0] rdata;
        logic [23:0] ad_out;
        logic ad_valid;
    } state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
    } io_req_type;
endpackage

// File: logic/distributed_dma_slave_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Decode a sixteen-byte I/O region at the configured channel base address.
// - Legacy bits without distributed use are read-only and do nothing.
// - Reserved locations in the region read back as all zeros.
// - Writes to reserved locations are taken but change nothing.
// - Sixteen-bit address register at offset zero, reset to zero.
// - Address write sets transfer start; read returns current reached address.
// - Eight-bit mode drives full current address on lines 15 to 0.
// - Eight-bit mode drives all page bits on lines 23 to 16.
// - Sixteen-bit mode drives address on lines 16 to 1, line 0 low.
// - Sixteen-bit mode drives page bits 7 to 1 on 23 to 17.
// - Eight-bit page register at offset two, reset to zero.
// - Byte count drops by one per 8-bit, two per 16-bit transfer.
// - Terminal-count flags set at terminal count, cleared by status read or reset.
// - Disable bit: zero enables the slave, one disables it.
module distributed_dma_slave_regs (
    input wire logic clk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic [15:0] dma_base, // Base address from configuration space
    input wire dma_slave_pkg::io_req_type io_req, // I/O access request
    input wire logic xfer_done, // One transfer completed
    input wire logic mode_16bit, // Sixteen-bit transfer mode
    input wire logic addr_phase, // Request to present the address
    output logic [31:0] io_rdata, // Read data
    output logic [23:0] ad_out, // Address phase value
    output logic ad_valid, // Address phase value valid
    output logic [3:0] terminal_count_flags, // Terminal count flags
    output logic controller_disable // Slave disabled
);
    import dma_slave_pkg::*;

    state_type s_q;
    state_type s_d;

    ////////////////////////////////////////////////////////////////////////
    // Region decode is shared by reads and writes.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        // Only the upper bits compare; the low nibble selects the register.
        return a[15:4] == b[15:4];
    endfunction

    logic sel;
    logic [3:0] off;
    logic tc_hit;
    logic [15:0] step;

    always_comb begin
        s_d = s_q;
        sel = hit(io_req.addr, dma_base);
        off = io_req.addr[3:0];
        step = mode_16bit ? step_16bit : step_8bit;
        tc_hit = 1'b0;
        s_d.rdata = 32'h0000_0000;
        if (sel && io_req.rd) begin
            if (off == off_address) begin
                s_d.rdata = {16'h0000, s_q.cur_addr};
            end else if (off == off_page) begin
                s_d.rdata = {24'h000000, s_q.page};
            end else if (off == off_count) begin
                s_d.rdata = {16'h0000, s_q.cur_count};
            end else if (off == off_status) begin
                // request status bits unused, read zero
                s_d.rdata = {28'h0000000, s_q.tc_flags};
            end
        end
        if (sel && io_req.rd && off == off_status) begin
            s_d.tc_flags = flags_reset;
        end
        if (!s_q.controller_disable && xfer_done) begin
            s_d.cur_addr = s_q.cur_addr + 16'h0001;
            if (s_q.cur_count <= step) begin
                s_d.cur_count = 16'h0000;
                tc_hit = 1'b1;
            end else begin
                s_d.cur_count = s_q.cur_count - step;
            end
        end
        // Set wins over the clear from a simultaneous status read.
        // Software polling the status could otherwise lose a terminal count.
        if (tc_hit) begin
            s_d.tc_flags = flags_set;
        end
        if (sel && io_req.wr) begin
            if (off == off_address) begin
                s_d.base_addr = io_req.wdata;
                s_d.cur_addr = io_req.wdata;
            end else if (off == off_page) begin
                s_d.page = io_req.wdata[7:0];
            end else if (off == off_count) begin
                s_d.base_count = io_req.wdata;
                s_d.cur_count = io_req.wdata;
            end else if (off == off_command) begin
                s_d.controller_disable = io_req.wdata[disable_bit];
            end
        end
        s_d.ad_valid = addr_phase && !s_q.controller_disable;
        if (mode_16bit) begin
            // shifted word address, page bit 0 dropped
            s_d.ad_out = {s_q.page[7:1], s_q.cur_addr, 1'b0};
        end else begin
            s_d.ad_out = {s_q.page, s_q.cur_addr};
        end
        if (rst) begin
            s_d.base_addr = address_reset;
            s_d.cur_addr = address_reset;
            s_d.page = page_reset;
            s_d.base_count = count_reset;
            s_d.cur_count = count_reset;
            s_d.tc_flags = flags_reset;
            s_d.controller_disable = disable_reset;
            s_d.rdata = 32'h0000_0000;
            s_d.ad_out = 24'h000000;
            s_d.ad_valid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign io_rdata = s_q.rdata;
    assign ad_out = s_q.ad_out;
    assign ad_valid = s_q.ad_valid;
    assign terminal_count_flags = s_q.tc_flags;
    assign controller_disable = s_q.controller_disable;

    ////////////////////////////////////////////////////////////////////////
    a_addr_write_load: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && hit(io_req.addr, dma_base) && io_req.addr[3:0] == off_address)
        |=> (s_q.cur_addr == $past(io_req.wdata) && s_q.base_addr == s_q.cur_addr))
        else $error("address write did not load both copies");
    a_reserved_read_zero: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && hit(io_req.addr, dma_base) && io_req.addr[3:0] == 4'hc)
        |=> io_rdata == 32'h0000_0000)
        else $error("reserved read not zero");
    a_reserved_write_none: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && io_req.addr[3:0] == 4'hc && !xfer_done && !io_req.rd)
        |=> $stable(s_q.cur_addr) && $stable(s_q.page) && $stable(controller_disable))
        else $error("reserved write changed state");
    a_outside_ignored: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && !hit(io_req.addr, dma_base)) |=> io_rdata == 32'h0000_0000)
        else $error("access outside region answered");
    a_mode8_layout: assert property (@(posedge clk) disable iff (rst)
        !mode_16bit |=> ad_out == {$past(s_q.page), $past(s_q.cur_addr)})
        else $error("8-bit address layout wrong");
    a_mode16_layout: assert property (@(posedge clk) disable iff (rst)
        mode_16bit |=> ad_out[0] == 1'b0 && ad_out[16:1] == $past(s_q.cur_addr))
        else $error("16-bit address layout wrong");
    a_mode16_page: assert property (@(posedge clk) disable iff (rst)
        mode_16bit |=> ad_out[23:17] == $past(s_q.page[7:1]))
        else $error("16-bit page layout wrong");
    a_count_step: assert property (@(posedge clk) disable iff (rst)
        (xfer_done && !controller_disable && !io_req.wr && s_q.cur_count > 16'h0002)
        |=> s_q.cur_count == $past(s_q.cur_count) - ($past(mode_16bit) ? 16'h0002 : 16'h0001))
        else $error("count step wrong");
    a_tc_set: assert property (@(posedge clk) disable iff (rst)
        tc_hit |=> terminal_count_flags == 4'hf)
        else $error("terminal count flags not set");
    a_disabled_holds: assert property (@(posedge clk) disable iff (rst)
        (controller_disable && !io_req.wr) |=> $stable(s_q.cur_count))
        else $error("disabled slave advanced");

    ////////////////////////////////////////////////////////////////////////
    // Register writes: each decoded write must land in its own field only.
    a_page_write_load: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && sel && off == off_page)
        |=>
        s_q.page == $past(io_req.wdata[7:0]))
        else $error("page write did not load");
    a_count_write_load: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && sel && off == off_count)
        |=>
        (s_q.cur_count == $past(io_req.wdata) && s_q.base_count == s_q.cur_count))
        else $error("count write did not load both copies");
    a_disable_write: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && sel && off == off_command)
        |=>
        controller_disable == $past(io_req.wdata[disable_bit]))
        else $error("command write did not set disable bit");
    a_base_holds: assert property (@(posedge clk) disable iff (rst)
        !(io_req.wr && sel && off == off_address)
        |=>
        $stable(s_q.base_addr))
        else $error("base address changed without a write");
    a_reserved_write_count: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && sel && off == 4'h6 && !xfer_done)
        |=>
        $stable(s_q.cur_count) && $stable(s_q.base_addr) && $stable(s_q.tc_flags))
        else $error("reserved write changed count or flags");
    a_outside_write_none: assert property (@(posedge clk) disable iff (rst)
        (io_req.wr && !sel && !xfer_done)
        |=>
        $stable(s_q.cur_addr) && $stable(s_q.page) && $stable(controller_disable))
        else $error("write outside region changed state");

    // Register reads: data stands for exactly one cycle after the request.
    a_addr_read_back: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && sel && off == off_address)
        |=>
        io_rdata == {16'h0000, $past(s_q.cur_addr)})
        else $error("address read returned wrong value");
    a_page_read_back: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && sel && off == off_page)
        |=>
        io_rdata == {24'h000000, $past(s_q.page)})
        else $error("page read returned wrong value");
    a_status_read_back: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && sel && off == off_status)
        |=>
        io_rdata == {28'h0000000, $past(s_q.tc_flags)})
        else $error("status read returned wrong value");
    a_request_read_zero: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && sel && off == 4'h9)
        |=>
        io_rdata == 32'h0000_0000)
        else $error("write-only legacy location read nonzero");
    a_idle_read_zero: assert property (@(posedge clk) disable iff (rst)
        !io_req.rd
        |=>
        io_rdata == 32'h0000_0000)
        else $error("read data without a read");

    // Transfer progress: address and count move only on an enabled transfer or a write to their register.
    a_addr_step: assert property (@(posedge clk) disable iff (rst)
        (xfer_done && !controller_disable && !(io_req.wr && sel && off == off_address))
        |=>
        s_q.cur_addr == $past(s_q.cur_addr) + 16'h0001)
        else $error("current address did not advance");
    a_disabled_addr_holds: assert property (@(posedge clk) disable iff (rst)
        (controller_disable && !io_req.wr)
        |=>
        $stable(s_q.cur_addr))
        else $error("disabled slave moved the address");
    a_count_holds_idle: assert property (@(posedge clk) disable iff (rst)
        (!xfer_done && !(io_req.wr && sel && off == off_count))
        |=>
        $stable(s_q.cur_count))
        else $error("count moved without a transfer");
    a_count_floor: assert property (@(posedge clk) disable iff (rst)
        (tc_hit && !io_req.wr)
        |=>
        s_q.cur_count == 16'h0000)
        else $error("count not zero at terminal count");

    // Terminal count flags: all four move together, set only by a transfer.
    a_flags_together: assert property (@(posedge clk) disable iff (rst)
        terminal_count_flags == flags_reset || terminal_count_flags == flags_set)
        else $error("terminal count flags split");
    a_flags_need_tc: assert property (@(posedge clk) disable iff (rst)
        $rose(terminal_count_flags[0])
        |->
        $past(tc_hit))
        else $error("flags set without terminal count");
    a_status_read_clear: assert property (@(posedge clk) disable iff (rst)
        (io_req.rd && sel && off == off_status && !tc_hit)
        |=>
        terminal_count_flags == flags_reset)
        else $error("status read did not clear flags");

    // Address phase: the valid strobe follows the request one cycle late.
    a_valid_follows: assert property (@(posedge clk) disable iff (rst)
        (addr_phase && !controller_disable)
        |=>
        ad_valid)
        else $error("address phase not presented");
    a_valid_blocked: assert property (@(posedge clk) disable iff (rst)
        (!addr_phase || controller_disable)
        |=>
        !ad_valid)
        else $error("address phase presented while idle or disabled");
    a_mode8_page: assert property (@(posedge clk) disable iff (rst)
        !mode_16bit
        |=>
        ad_out[23:16] == $past(s_q.page))
        else $error("8-bit page layout wrong");

    // Reset: checked without the disable so the reset cycle itself is seen.
    a_reset_values: assert property (@(posedge clk)
        rst
        |=>
        (s_q.cur_addr == address_reset && s_q.base_addr == address_reset
            && s_q.page == page_reset && s_q.cur_count == count_reset
            && terminal_count_flags == flags_reset && controller_disable == disable_reset))
        else $error("reset values wrong");
endmodule

// File: tb/dma_master_model.sv
`timescale 1ns/100ps
// Master side: each request yields one transfer pulse after a fixed gap.
module dma_master_model #(
    parameter int gap = 2
) (
    input wire logic clk, // Clock
    input wire logic go, // Request one transfer
    output logic xfer_done // One transfer finished
);
    initial xfer_done = 1'b0;
    always @(posedge go) begin
        repeat (gap) @(negedge clk);
        xfer_done = 1'b1;
        @(negedge clk);
        xfer_done = 1'b0;
    end
endmodule

// File: tb/distributed_dma_slave_regs_tb.sv
`timescale 1ns/100ps
module distributed_dma_slave_regs_tb;
    import dma_slave_pkg::*;
    typedef struct packed {logic wr; logic [3:0] off; logic [15:0] wd; logic [31:0] ex;} row_type;
    logic clk, rst, xfer_done, mode_16bit, addr_phase, go, ad_valid, controller_disable;
    logic [15:0] dma_base;
    io_req_type io_req;
    logic [31:0] io_rdata;
    logic [31:0] rd_data;
    logic [23:0] ad_out;
    logic [3:0] terminal_count_flags;
    int mismatches, check_count;
    row_type rows [10];
    distributed_dma_slave_regs u_distributed_dma_slave_regs (.clk(clk), .rst(rst),
        .dma_base(dma_base), .io_req(io_req), .xfer_done(xfer_done), .mode_16bit(mode_16bit),
        .addr_phase(addr_phase), .io_rdata(io_rdata), .ad_out(ad_out), .ad_valid(ad_valid),
        .terminal_count_flags(terminal_count_flags), .controller_disable(controller_disable));
    dma_master_model #(.gap(2)) u_dma_master_model (.clk(clk), .go(go), .xfer_done(xfer_done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, ex, got);
        end
    endtask
    // Read data stands one cycle, so it is caught at the falling edge after the request.
    // An idle cycle follows so that back-to-back calls never drive the request twice at once.
    task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d);
        io_req = '{wr, ~wr, a, d, 2'h3};
        @(negedge clk);
        rd_data = io_rdata;
        io_req = '0;
        @(negedge clk);
    endtask
    task automatic xfer();
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic results();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {go, mode_16bit, addr_phase} = 3'h0;
        mismatches = 0;
        check_count = 0;
        io_req = '0;
        dma_base = 16'h0340;
        rows = '{'{0, 4'h0, 0, 0}, '{0, 4'h2, 0, 0}, '{1, 4'h0, 16'ha5c3, 0},
            '{0, 4'h0, 0, 32'ha5c3}, '{1, 4'h2, 16'h009b, 0}, '{0, 4'h2, 0, 32'h9b},
            '{1, 4'h6, 16'hffff, 0}, '{0, 4'h6, 0, 0}, '{1, 4'hc, 16'hffff, 0}, '{0, 4'hc, 0, 0}};
        repeat (8) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            io(rows[i].wr, dma_base | 16'(rows[i].off), rows[i].wd);
            if (!rows[i].wr) chk("row read", rows[i].ex, rd_data);
        end
        io(1, 16'h0350, 16'h1111);
        io(0, 16'h0340, 0);
        chk("outside region", 32'ha5c3, rd_data);
        addr_phase = 1'b1;
        @(negedge clk);
        chk("ad 8-bit", {8'h1, 8'h9b, 16'ha5c3}, {7'h0, ad_valid, ad_out});
        mode_16bit = 1'b1;
        @(negedge clk);
        chk("ad 16-bit", {8'h1, 7'h4d, 16'ha5c3, 1'b0}, {7'h0, ad_valid, ad_out});
        io(1, 16'h0348, 16'h00ff);
        @(negedge clk);
        chk("disabled", 32'h1, {ad_valid, 30'h0, controller_disable});
        io(0, 16'h0348, 0);
        chk("status", 0, rd_data);
        io(0, 16'h0349, 0);
        chk("request reads zero", 0, rd_data);
        io(1, 16'h0348, 0);
        addr_phase = 1'b0;
        io(1, 16'h0344, 16'h0003);
        xfer();
        io(0, 16'h0344, 0);
        chk("count 16-bit", 32'h1, rd_data);
        io(0, 16'h0340, 0);
        chk("address step", 32'ha5c4, rd_data);
        xfer();
        chk("flags set", 32'hf, 32'(terminal_count_flags));
        io(0, 16'h0348, 0);
        chk("status tc", 32'hf, rd_data);
        io(0, 16'h0348, 0);
        chk("status cleared", 0, rd_data);
        mode_16bit = 1'b0;
        io(1, 16'h0344, 16'h0005);
        xfer();
        io(0, 16'h0344, 0);
        chk("count 8-bit", 32'h4, rd_data);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        io(0, 16'h0340, 0);
        chk("address reset", 0, rd_data);
        io(0, 16'h0342, 0);
        chk("page reset", 0, rd_data);
        results();
    end
    // The sequence needs about 75 cycles; allow ample margin before declaring a hang.
    initial begin
        #5000;
        mismatches++;
        results();
    end
endmodule
